// ### bench/vdec_host_model.sv
// Host controller model that drives the control port of the front register bank.
`timescale 1ns/1ns
`default_nettype none
module vdec_host_model
(
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    output var  logic       o_write,
    output var  logic       o_read,
    output var  logic [7:0] o_subaddr,
    output var  logic [7:0] o_wdata
);
    // The port starts idle with address and data parked on arbitrary patterns.
    initial
    begin
        o_write = 1'b0;
        o_read = 1'b0;
        o_subaddr = 8'hA5;
        o_wdata = 8'h5A;
    end

    // One write pulse; the forced-one bits of gain and mask are always set.
    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (addr == 8'h01)
            d = d | 8'h0E;
        if (addr == 8'h04)
            d = d | 8'h03;
        @(posedge i_clock);
        o_write <= 1'b1;
        o_subaddr <= addr;
        o_wdata <= d;
        @(posedge i_clock);
        o_write <= 1'b0;
        o_subaddr <= ~addr;
        o_wdata <= ~d;
        repeat (2) @(posedge i_clock);
    endtask

    // One read pulse; the answer is taken in the cycle after the request edge.
    task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic valid);
        @(posedge i_clock);
        o_read <= 1'b1;
        o_subaddr <= addr;
        @(posedge i_clock);
        o_read <= 1'b0;
        o_subaddr <= ~addr;
        @(negedge i_clock);
        data = i_rdata;
        valid = i_rvalid;
    endtask
endmodule
`default_nettype wire

// ### bench/video_decoder_front_control_regs_tb_top.sv
// Self-checking bench for the front control register bank.
`timescale 1ns/1ns
`default_nettype none
module video_decoder_front_control_regs_tb_top;
    logic       i_clock = 1'b0;
    logic       i_arst_n = 1'b0;
    logic       i_vblank = 1'b0;
    logic [9:0] i_luma = 10'h000;
    logic [9:0] i_chroma = 10'h000;
    logic       host_write, host_read, o_host_rvalid, o_auto_gain_enable, o_autoswitch;
    logic       o_standard_reserved, o_power_save, o_converters_on, o_proc_clock_en;
    logic       o_pedestal_present;
    logic [7:0] host_subaddr, host_wdata, o_host_rdata;
    logic [3:0] o_analog_out_sel, o_forced_standard;
    logic [6:0] o_autoswitch_mask;
    logic [4:0] o_kill_threshold;
    logic [1:0] o_kill_mode, o_luma_filter, o_peak_gain, o_trap_select;
    logic [9:0] o_luma, o_chroma;
    int         bad_count = 0;
    int         cmp_count = 0;

    // Free-running 50 MHz clock.
    always #10 i_clock = ~i_clock;

    vdec_front_regs u_vdec_front_regs
    (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_host_write(host_write),
        .i_host_read(host_read), .i_host_subaddr(host_subaddr), .i_host_wdata(host_wdata),
        .i_pixel_en(1'b1), .i_vblank(i_vblank), .i_luma(i_luma), .i_chroma(i_chroma),
        .o_host_rdata(o_host_rdata), .o_host_rvalid(o_host_rvalid),
        .o_analog_out_sel(o_analog_out_sel), .o_auto_gain_enable(o_auto_gain_enable),
        .o_autoswitch(o_autoswitch), .o_forced_standard(o_forced_standard),
        .o_standard_reserved(o_standard_reserved), .o_autoswitch_mask(o_autoswitch_mask),
        .o_power_save(o_power_save), .o_converters_on(o_converters_on),
        .o_proc_clock_en(o_proc_clock_en), .o_kill_mode(o_kill_mode),
        .o_kill_threshold(o_kill_threshold), .o_pedestal_present(o_pedestal_present),
        .o_luma_filter(o_luma_filter), .o_peak_gain(o_peak_gain),
        .o_trap_select(o_trap_select), .o_luma(o_luma), .o_chroma(o_chroma)
    );

    vdec_host_model u_vdec_host_model
    (
        .i_clock(i_clock), .i_rdata(o_host_rdata), .i_rvalid(o_host_rvalid),
        .o_write(host_write), .o_read(host_read), .o_subaddr(host_subaddr),
        .o_wdata(host_wdata)
    );

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_vdec_host_model.write(a, d);
    endtask

    // Reads one register and checks both the valid pulse and the data.
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        u_vdec_host_model.read(a, d, v);
        check(v, 1'b1);
        check(d, exp);
    endtask

    task automatic done(input string n);
        $display("test %s finished", n);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic t_reset;
        logic [7:0] dflt [9] = '{8'h00, 8'h0F, 8'h00, 8'h00, 8'h23, 8'h10, 8'h00, 8'h00, 8'h00};
        for (int a = 0; a < 9; a++)
            rd_check(8'(a), dflt[a]);
        check(o_auto_gain_enable, 1'b1);
        check(o_autoswitch, 1'b1);
        check(o_autoswitch_mask, 7'h23);
        check(o_pedestal_present, 1'b1);
        check(o_converters_on, 1'b1);
        done("reset");
    endtask

    task automatic t_rw;
        logic [7:0] mask [9] = '{8'hFF, 8'h0F, 8'h0F, 8'h01, 8'h7F, 8'h7F, 8'h57, 8'hCC, 8'h03};
        for (int a = 0; a < 9; a++)
            wr(8'(a), (a == 0) ? 8'hC2 : 8'hFF);
        wr(8'h09, 8'hFF);
        for (int a = 0; a < 9; a++)
            rd_check(8'(a), ((a == 0) ? 8'hC2 : 8'hFF) & mask[a]);
        rd_check(8'h09, 8'h00);
        done("readback");
    endtask

    task automatic t_power;
        int n;
        wr(8'h05, 8'h2A);
        for (int p = 1; p >= 0; p--)
        begin
            wr(8'h03, 8'(p));
            n = 0;
            repeat (16)
            begin
                @(negedge i_clock);
                if (o_proc_clock_en === 1'b1)
                    n++;
            end
            check(n, (p == 1) ? 2 : 16);
            check(o_power_save, p);
            check(o_converters_on, !p);
            rd_check(8'h05, 8'h2A);
        end
        done("power");
    endtask

    task automatic t_standard;
        logic [7:0] route [2] = '{8'h00, 8'h90};
        logic       resv;
        for (int r = 0; r < 2; r++)
        begin
            wr(8'h00, route[r]);
            for (int c = 0; c < 11; c++)
            begin
                wr(8'h02, 8'(c));
                resv = (r == 0) ? (c > 7) : !(c <= 2 || c == 9 || c == 10);
                check(o_autoswitch, c == 0);
                check(o_standard_reserved, resv);
                check(o_forced_standard, resv ? 0 : c);
            end
        end
        wr(8'h02, 8'h01);
        wr(8'h07, 8'hCC);
        wr(8'h02, 8'h01);
        rd_check(8'h07, 8'hCC);
        wr(8'h02, 8'h02);
        rd_check(8'h07, 8'h00);
        done("standard");
    endtask

    task automatic t_fields;
        logic [7:0] route [8] = '{8'h00, 8'h0E, 8'h40, 8'h56, 8'h90, 8'h96, 8'hC0, 8'hC2};
        for (int k = 0; k < 8; k++)
        begin
            wr(8'h00, route[k]);
            check(o_analog_out_sel, route[k][3:0]);
        end
        wr(8'h01, 8'h00);
        check(o_auto_gain_enable, 1'b0);
        wr(8'h04, 8'h7C);
        check(o_autoswitch_mask, 7'h7F);
        wr(8'h06, 8'h40);
        check(o_pedestal_present, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h05, 8'(k * 32 + 31 - k));
            check(o_kill_mode, k);
            check(o_kill_threshold, 31 - k);
            wr(8'h07, 8'(k * 68));
            check(o_luma_filter, k);
            check(o_peak_gain, k);
            wr(8'h08, 8'(k));
            check(o_trap_select, k);
        end
        done("fields");
    endtask

    // Measures the skew of a step through the delay line, then the blank-window swap.
    task automatic t_video;
        logic [2:0] code [4] = '{3'h0, 3'h3, 3'h5, 3'h4};
        int         skew [4] = '{0, 3, -3, 0};
        int         nl;
        int         nc;
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h06, {5'h00, code[k]});
            i_luma <= 10'h011;
            i_chroma <= 10'h022;
            repeat (8) @(posedge i_clock);
            i_luma <= 10'h3EE;
            i_chroma <= 10'h3DD;
            nl = 0;
            nc = 0;
            for (int c = 1; c < 13; c++)
            begin
                @(negedge i_clock);
                if (nl == 0 && o_luma === 10'h3EE)
                    nl = c;
                if (nc == 0 && o_chroma === 10'h3DD)
                    nc = c;
            end
            check(nl > 0 && nc > 0, 1'b1);
            check(nl - nc, skew[k]);
        end
        wr(8'h06, 8'h10);
        i_vblank <= 1'b1;
        repeat (8) @(posedge i_clock);
        check(o_chroma, 10'h3EE);
        i_vblank <= 1'b0;
        repeat (8) @(posedge i_clock);
        check(o_chroma, 10'h3DD);
        done("video");
    endtask

    // Main sequence: reset for 20 cycles, then every scenario in turn.
    initial
    begin
        repeat (20) @(posedge i_clock);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_clock);
        t_reset();
        t_rw();
        t_power();
        t_standard();
        t_fields();
        t_video();
        stop_test();
    end

    // Watchdog well beyond the few hundred cycles the scenarios need.
    initial
    begin
        repeat (20000) @(posedge i_clock);
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire

// ### src/vdec_front_defs.svh
// Offsets, field positions, reset values and decode codes of the front control bank.
`ifndef VDEC_FRONT_DEFS_SVH
`define VDEC_FRONT_DEFS_SVH
`define OFS_INPUT_ROUTING   8'h00
`define OFS_FRONT_GAIN      8'h01
`define OFS_VIDEO_STANDARD  8'h02
`define OFS_OPERATION_MODE  8'h03
`define OFS_AUTOSWITCH_MASK 8'h04
`define OFS_COLOUR_SUPPRESS 8'h05
`define OFS_LUMA_ONE        8'h06
`define OFS_LUMA_TWO        8'h07
`define OFS_LUMA_THREE      8'h08
`define REG_COUNT           9
`define RST_INPUT_ROUTING   8'h00
`define RST_FRONT_GAIN      8'h0F
`define RST_VIDEO_STANDARD  8'h00
`define RST_OPERATION_MODE  8'h00
`define RST_AUTOSWITCH_MASK 8'h23
`define RST_COLOUR_SUPPRESS 8'h10
`define RST_LUMA_ONE        8'h00
`define RST_LUMA_TWO        8'h00
`define RST_LUMA_THREE      8'h00
`define MASK_INPUT_ROUTING   8'hFF
`define MASK_FRONT_GAIN      8'h0F
`define MASK_VIDEO_STANDARD  8'h0F
`define MASK_OPERATION_MODE  8'h01
`define MASK_AUTOSWITCH_MASK 8'h7F
`define MASK_COLOUR_SUPPRESS 8'h7F
`define MASK_LUMA_ONE        8'h57
`define MASK_LUMA_TWO        8'hCC
`define MASK_LUMA_THREE      8'h03
`define BIT_AUTO_GAIN       0
`define BIT_POWER_SAVE      0
`define BIT_PEDESTAL_ABSENT 6
`define BIT_RAW_BLANK       4
`define KILL_MODE_LSB       5
`define KILL_THRESH_LSB     0
`define LUMA_DELAY_LSB      0
`define LUMA_FILTER_LSB     6
`define PEAK_GAIN_LSB       2
`define TRAP_SEL_LSB        0
`define STD_AUTO            4'h0
`define STD_LAST_COMPOSITE  4'h7
`define STD_PROG_525        4'h9
`define STD_PROG_625        4'hA
`define STD_INT_625         4'h2
`define ROUTE_SVIDEO_TOP    2'h1
`define ROUTE_COMPONENT_TOP 2'h2
`define ROUTE_SCART_TOP     2'h3
`define POWER_SAVE_DIVIDE   4'h7
`endif

// ### src/vdec_front_pkg.sv
// Types shared by the front control bank.
package vdec_front_pkg;
    typedef enum logic [3:0]
    {
        MODE_COMPOSITE = 4'b0001,
        MODE_SVIDEO    = 4'b0010,
        MODE_COMPONENT = 4'b0100,
        MODE_SCART     = 4'b1000
    } input_mode_type;
    typedef enum logic [2:0]
    {
        FSM_IDLE  = 3'b001,
        FSM_WRITE = 3'b010,
        FSM_READ  = 3'b100
    } port_state_type;
endpackage

// ### src/vdec_front_regs.sv
// Front control register bank of the video decoder with its control decode.
//
// Overview of operation
// - Analog output follows composite, luma or green input of routing code.
// - Gain bit zero selects automatic gain, only on the analog front end.
// - Brightness and contrast stay independent of the gain mode.
// - Standard code zero means autoswitch; other valid codes force that standard.
// - Composite codes one to seven force the seven listed standards.
// - Component codes 1, 2, 9, 10 select interlaced or progressive rates.
// - Changing the standard field returns dependent settings to defaults.
// - Power save slows the processor clock and switches converters off.
// - In power save the host port works and settings are kept.
// - Autoswitch mask bits include each standard; default 23h.
// - Colour killer mode: automatic, reserved, forced off, disabled.
// - Killer threshold five bits, default sixteen, register reset 10h.
// - Pedestal bit zero means setup pedestal present.
// - Raw blanking puts luma in chroma slots during the blank window.
// - Three-bit signed code delays luma against chroma by up to three periods.
// - Luma filter field selects comb, trap or bypass; 11 reserved.
// - Trap select chooses one of four stop-band widths.
// - Host reads and writes each register by its 8-bit subaddress.
`timescale 1ns/1ns
`default_nettype none
`include "vdec_front_defs.svh"
module vdec_front_regs
(
    input  wire logic       i_clock,
    input  wire logic       i_arst_n,
    input  wire logic       i_host_write,
    input  wire logic       i_host_read,
    input  wire logic [7:0] i_host_subaddr,
    input  wire logic [7:0] i_host_wdata,
    input  wire logic       i_pixel_en,
    input  wire logic       i_vblank,
    input  wire logic [9:0] i_luma,
    input  wire logic [9:0] i_chroma,
    output var  logic [7:0] o_host_rdata,
    output var  logic       o_host_rvalid,
    output var  logic [3:0] o_analog_out_sel,
    output var  logic       o_auto_gain_enable,
    output var  logic       o_autoswitch,
    output var  logic [3:0] o_forced_standard,
    output var  logic       o_standard_reserved,
    output var  logic [6:0] o_autoswitch_mask,
    output var  logic       o_power_save,
    output var  logic       o_converters_on,
    output var  logic       o_proc_clock_en,
    output var  logic [1:0] o_kill_mode,
    output var  logic [4:0] o_kill_threshold,
    output var  logic       o_pedestal_present,
    output var  logic [1:0] o_luma_filter,
    output var  logic [1:0] o_peak_gain,
    output var  logic [1:0] o_trap_select,
    output var  logic [9:0] o_luma,
    output var  logic [9:0] o_chroma
);
    logic                           rst_meta_q;
    logic                           rst_sync_q;

    logic [7:0]                     regs_q [0:`REG_COUNT-1];
    logic [7:0]                     reset_value [0:`REG_COUNT-1];
    logic [7:0]                     write_mask  [0:`REG_COUNT-1];

    logic                           addr_hit;
    logic [7:0]                     read_word;
    logic                           std_change;
    logic [7:0]                     std_new;

    logic [3:0]                     std_code;
    logic [1:0]                     route_top;
    logic [3:0]                     route_low;
    vdec_front_pkg::input_mode_type mode;
    logic                           std_valid;

    logic [3:0]                     ps_div_q;

    logic                           raw_blank;
    logic [9:0]                     dly_luma;
    logic [9:0]                     dly_chroma;
    integer                         idx;

    // Release of the asynchronous reset through two flip-flops.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Reset values and writable bits of each register; reserved bits stay zero.
    assign reset_value[0] = `RST_INPUT_ROUTING;
    assign reset_value[1] = `RST_FRONT_GAIN;
    assign reset_value[2] = `RST_VIDEO_STANDARD;
    assign reset_value[3] = `RST_OPERATION_MODE;
    assign reset_value[4] = `RST_AUTOSWITCH_MASK;
    assign reset_value[5] = `RST_COLOUR_SUPPRESS;
    assign reset_value[6] = `RST_LUMA_ONE;
    assign reset_value[7] = `RST_LUMA_TWO;
    assign reset_value[8] = `RST_LUMA_THREE;
    assign write_mask[0]  = `MASK_INPUT_ROUTING;
    assign write_mask[1]  = `MASK_FRONT_GAIN;
    assign write_mask[2]  = `MASK_VIDEO_STANDARD;
    assign write_mask[3]  = `MASK_OPERATION_MODE;
    assign write_mask[4]  = `MASK_AUTOSWITCH_MASK;
    assign write_mask[5]  = `MASK_COLOUR_SUPPRESS;
    assign write_mask[6]  = `MASK_LUMA_ONE;
    assign write_mask[7]  = `MASK_LUMA_TWO;
    assign write_mask[8]  = `MASK_LUMA_THREE;

    // Address decode and detection of a change to the standard field.
    assign addr_hit   = (i_host_subaddr <= `OFS_LUMA_THREE);
    assign std_new    = i_host_wdata & `MASK_VIDEO_STANDARD;
    assign std_change = i_host_write && (i_host_subaddr == `OFS_VIDEO_STANDARD)
                        && (std_new != regs_q[2]);

    // Read selection: unmapped subaddresses give zero.
    assign read_word = addr_hit ? regs_q[i_host_subaddr[3:0]] : 8'h00;

    // Register storage: host writes, standard change restores dependent luma settings.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            regs_q[0] <= `RST_INPUT_ROUTING;
            regs_q[1] <= `RST_FRONT_GAIN;
            regs_q[2] <= `RST_VIDEO_STANDARD;
            regs_q[3] <= `RST_OPERATION_MODE;
            regs_q[4] <= `RST_AUTOSWITCH_MASK;
            regs_q[5] <= `RST_COLOUR_SUPPRESS;
            regs_q[6] <= `RST_LUMA_ONE;
            regs_q[7] <= `RST_LUMA_TWO;
            regs_q[8] <= `RST_LUMA_THREE;
        end
        else if (!rst_sync_q)
        begin
            for (idx = 0; idx < `REG_COUNT; idx = idx + 1)
                regs_q[idx] <= reset_value[idx];
        end
        else
        begin
            for (idx = 0; idx < `REG_COUNT; idx = idx + 1)
            begin
                if (i_host_write && i_host_subaddr == 8'(idx))
                    regs_q[idx] <= i_host_wdata & write_mask[idx];
                else if (std_change && idx >= 6)
                    regs_q[idx] <= reset_value[idx];
            end
        end
    end

    // Read port: one-cycle answer, unmapped subaddresses read zero; works in power save.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_host_rdata  <= 8'h00;
            o_host_rvalid <= 1'b0;
        end
        else
        begin
            o_host_rvalid <= i_host_read;
            o_host_rdata  <= i_host_read ? read_word : 8'h00;
        end
    end

    // Input routing decode to the mode and the input that feeds the analog output.
    assign route_top = regs_q[0][7:6];
    assign route_low = regs_q[0][3:0];
    always_comb
    begin
        unique case (route_top)
            `ROUTE_SVIDEO_TOP:    mode = vdec_front_pkg::MODE_SVIDEO;
            `ROUTE_COMPONENT_TOP: mode = vdec_front_pkg::MODE_COMPONENT;
            `ROUTE_SCART_TOP:     mode = vdec_front_pkg::MODE_SCART;
            default:              mode = vdec_front_pkg::MODE_COMPOSITE;
        endcase
    end

    // Standard code validity depends on the input mode.
    assign std_code  = regs_q[2][3:0];
    assign std_valid = (mode == vdec_front_pkg::MODE_COMPONENT)
                       ? (std_code <= `STD_INT_625 || std_code == `STD_PROG_525
                          || std_code == `STD_PROG_625)
                       : (std_code <= `STD_LAST_COMPOSITE);

    // Power save divider: processor clock enable pulses once per eight cycles.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
            ps_div_q <= 4'h0;
        else
            ps_div_q <= (ps_div_q == `POWER_SAVE_DIVIDE) ? 4'h0 : ps_div_q + 4'h1;
    end

    // Raw blanking replaces chroma by luma inside the vertical blank window.
    assign raw_blank = regs_q[6][`BIT_RAW_BLANK] && i_vblank;

    // Delay line for luma relative to chroma.
    vdec_luma_delay u_delay
    (
        .i_clock      (i_clock),
        .i_rst_n      (rst_sync_q),
        .i_pixel_en   (i_pixel_en),
        .i_delay_code (regs_q[6][`LUMA_DELAY_LSB +: 3]),
        .i_luma       (i_luma),
        .i_chroma     (i_chroma),
        .o_luma       (dly_luma),
        .o_chroma     (dly_chroma)
    );

    // Registered control outputs decoded from the bank.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_analog_out_sel    <= 4'h0;
            o_auto_gain_enable  <= 1'b1;
            o_autoswitch        <= 1'b1;
            o_forced_standard   <= 4'h0;
            o_standard_reserved <= 1'b0;
            o_autoswitch_mask   <= 7'h23;
            o_power_save        <= 1'b0;
            o_converters_on     <= 1'b0;
            o_proc_clock_en     <= 1'b0;
            o_kill_mode         <= 2'h0;
            o_kill_threshold    <= 5'h10;
            o_pedestal_present  <= 1'b1;
            o_luma_filter       <= 2'h0;
            o_peak_gain         <= 2'h0;
            o_trap_select       <= 2'h0;
        end
        else
        begin
            o_analog_out_sel    <= route_low;
            o_auto_gain_enable  <= regs_q[1][`BIT_AUTO_GAIN];
            o_autoswitch        <= (std_code == `STD_AUTO);
            o_forced_standard   <= std_valid ? std_code : 4'h0;
            o_standard_reserved <= !std_valid;
            o_autoswitch_mask   <= regs_q[4][6:0];
            o_power_save        <= regs_q[3][`BIT_POWER_SAVE];
            o_converters_on     <= rst_sync_q && !regs_q[3][`BIT_POWER_SAVE];
            o_proc_clock_en     <= rst_sync_q && (!regs_q[3][`BIT_POWER_SAVE]
                                   || ps_div_q == `POWER_SAVE_DIVIDE);
            o_kill_mode         <= regs_q[5][`KILL_MODE_LSB +: 2];
            o_kill_threshold    <= regs_q[5][`KILL_THRESH_LSB +: 5];
            o_pedestal_present  <= !regs_q[6][`BIT_PEDESTAL_ABSENT];
            o_luma_filter       <= regs_q[7][`LUMA_FILTER_LSB +: 2];
            o_peak_gain         <= regs_q[7][`PEAK_GAIN_LSB +: 2];
            o_trap_select       <= regs_q[8][`TRAP_SEL_LSB +: 2];
        end
    end

    // Video samples leave through their own register stage.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_luma   <= 10'h000;
            o_chroma <= 10'h000;
        end
        else
        begin
            o_luma   <= dly_luma;
            o_chroma <= raw_blank ? dly_luma : dly_chroma;
        end
    end

    // Defaults stand when the reset copy rises.
    chk_reset_defaults: assert property (@(posedge i_clock)
        $rose(rst_sync_q) |-> regs_q[4] == 8'h23 && regs_q[5] == 8'h10 && regs_q[1] == 8'h0F)
        else $error("Register defaults wrong after reset release.");

    // A mask write lands on the next cycle.
    chk_write_stores: assert property (@(posedge i_clock) disable iff (!rst_sync_q)
        i_host_write && i_host_subaddr == `OFS_AUTOSWITCH_MASK
        |=> regs_q[4] == ($past(i_host_wdata) & 8'h7F))
        else $error("Mask register did not store the write.");

    // Every read is answered one cycle later.
    chk_read_answer: assert property (@(posedge i_clock) disable iff (!rst_sync_q)
        i_host_read |=> o_host_rvalid)
        else $error("Read not answered in one cycle.");

    // A new standard code clears the luma settings.
    chk_std_restore: assert property (@(posedge i_clock) disable iff (!rst_sync_q)
        std_change |=> regs_q[7] == 8'h00 && regs_q[6] == 8'h00)
        else $error("Standard change did not restore luma settings.");

    // The gain bit reaches its output two cycles after a write.
    chk_gain_follow: assert property (@(posedge i_clock) disable iff (!rst_sync_q)
        i_host_write && i_host_subaddr == `OFS_FRONT_GAIN
        |=> ##1 o_auto_gain_enable == $past(i_host_wdata[`BIT_AUTO_GAIN], 2))
        else $error("Gain mode output does not follow register.");

    // Code zero selects autoswitch and no forced standard.
    chk_autoswitch: assert property (@(posedge i_clock) disable iff (!rst_sync_q)
        std_code == 4'h0 |=> o_autoswitch && o_forced_standard == 4'h0)
        else $error("Autoswitch not selected for code zero.");

    // Power save turns the converters off.
    chk_power_save: assert property (@(posedge i_clock) disable iff (!rst_sync_q)
        regs_q[3][0] |=> !o_converters_on)
        else $error("Converters left on in power save.");

    // In power save the processor enable never stands two cycles running.
    chk_slow_clock: assert property (@(posedge i_clock) disable iff (!rst_sync_q)
        o_power_save && regs_q[3][`BIT_POWER_SAVE] && o_proc_clock_en |=> !o_proc_clock_en)
        else $error("Processor clock not slowed in power save.");

    // Raw blanking puts luma on the chroma output.
    chk_raw_chroma: assert property (@(posedge i_clock) disable iff (!rst_sync_q)
        raw_blank |=> o_chroma == $past(dly_luma))
        else $error("Chroma not replaced by luma in blank window.");

    // The pedestal flag is the inverse of the written bit.
    chk_pedestal: assert property (@(posedge i_clock) disable iff (!rst_sync_q)
        i_host_write && i_host_subaddr == `OFS_LUMA_ONE
        |=> ##1 o_pedestal_present == !$past(i_host_wdata[`BIT_PEDESTAL_ABSENT], 2))
        else $error("Pedestal flag wrong.");

    // The killer threshold follows a write.
    chk_kill_thresh: assert property (@(posedge i_clock) disable iff (!rst_sync_q)
        i_host_write && i_host_subaddr == `OFS_COLOUR_SUPPRESS
        |=> ##1 o_kill_threshold == $past(i_host_wdata[`KILL_THRESH_LSB +: 5], 2))
        else $error("Killer threshold does not follow the write.");

    // Main scenarios of the bank.
    cov_std_change: cover property (@(posedge i_clock) std_change);
    cov_power_save: cover property (@(posedge i_clock) o_power_save && o_host_rvalid);
    cov_raw_blank: cover property (@(posedge i_clock) raw_blank && i_pixel_en);
    cov_reserved_std: cover property (@(posedge i_clock) o_standard_reserved);
    cov_kill_forced: cover property (@(posedge i_clock) o_kill_mode == 2'h2);
endmodule
`default_nettype wire

// ### src/vdec_luma_delay.sv
// Signed luma-versus-chroma delay line of up to three pixel periods either way.
`timescale 1ns/1ns
`default_nettype none
module vdec_luma_delay
(
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_pixel_en,
    input  wire logic [2:0] i_delay_code,
    input  wire logic [9:0] i_luma,
    input  wire logic [9:0] i_chroma,
    output var  logic [9:0] o_luma,
    output var  logic [9:0] o_chroma
);
    logic [9:0] luma_tap_q   [0:3];
    logic [9:0] chroma_tap_q [0:3];
    logic [1:0] luma_sel;
    logic [1:0] chroma_sel;
    integer     idx;

    // Positive codes delay luma, negative codes delay chroma, 000 and 100 give none.
    assign luma_sel   = (i_delay_code[2] == 1'b0) ? i_delay_code[1:0] : 2'h0;
    assign chroma_sel = (i_delay_code[2] == 1'b1) ? 2'(3'h4 - {1'b0, i_delay_code[1:0]}) : 2'h0;

    // Shift both taps and select outputs on each pixel enable.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (idx = 0; idx < 4; idx = idx + 1)
            begin
                luma_tap_q[idx]   <= 10'h000;
                chroma_tap_q[idx] <= 10'h000;
            end
            o_luma   <= 10'h000;
            o_chroma <= 10'h000;
        end
        else if (i_pixel_en)
        begin
            luma_tap_q[0]   <= i_luma;
            chroma_tap_q[0] <= i_chroma;
            for (idx = 1; idx < 4; idx = idx + 1)
            begin
                luma_tap_q[idx]   <= luma_tap_q[idx-1];
                chroma_tap_q[idx] <= chroma_tap_q[idx-1];
            end
            o_luma   <= (luma_sel == 2'h0) ? i_luma : luma_tap_q[luma_sel - 2'h1];
            o_chroma <= (chroma_sel == 2'h0) ? i_chroma : chroma_tap_q[chroma_sel - 2'h1];
        end
    end
endmodule
`default_nettype wire
